//--- hdl/clkcfg_cfg.svh
// offsets, field positions, reset values and timing counts
`ifndef CLKCFG_CFG_SVH
`define CLKCFG_CFG_SVH
`define OFS_PLL_INPUT_DIVIDER 7'h04
`define OFS_PLL_SETTING_0 7'h06
`define OFS_PLL_SETTING_1 7'h08
`define OFS_PLL_SETTING_2 7'h0A
`define OFS_PLL_SETTING_3 7'h0C
`define OFS_PLL_MULTIPLIER 7'h0E
`define OFS_DUMMY_INCREMENT 7'h10
`define OFS_CLOCK_SOURCE_SELECT 7'h12
`define OFS_MEM_PORT_LO 7'h48
`define OFS_GAMMA_DATA 7'h54
`define OFS_SLEEP 7'h56
`define OFS_CTL_CMD 7'h00
`define OFS_CTL_STATUS 7'h01
`define OFS_CTL_MASK 7'h02
`define OFS_CTL_ADDR 7'h03
`define OFS_CTL_WDATA 7'h04
`define OFS_CTL_RDATA 7'h05
`define BIT_LOCK 7
`define BIT_SRC_SEL 0
`define BIT_SLEEP 1
`define RESET_BYTE 8'h00
`define SETTING_0_VALUE 8'hF8
`define SETTING_1_VALUE 8'h80
`define SETTING_2_VALUE 8'h28
`define SETTING_3_VALUE 8'h00
`define SETTLE_MS 10
`define CLK_MHZ 125
`define SETTLE_CYCLES (`SETTLE_MS * 1000 * `CLK_MHZ)
`endif

//--- hdl/clkcfg_pkg.sv
// types of the clock configuration link, used only by the clock block end
package clkcfg_pkg;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ = 2'b10
   } bus_op_t;
   typedef enum logic [1:0] {
      PLL_OFF = 2'b00,
      PLL_SETTLING = 2'b01,
      PLL_LOCKED = 2'b10
   } pll_state_t;
endpackage : clkcfg_pkg

//--- hdl/clkcfg_if.sv
// parallel host bus between the clock block and its host controller
`timescale 1ns/1ps
interface clkcfg_if;
   logic cs;
   logic dc;
   logic wr;
   logic rd;
   logic [15:0] md_host;
   logic [15:0] md_dev;
   logic md_dev_oe;
   logic bus_width_config_pin;
   modport device (
      input cs,
      input dc,
      input wr,
      input rd,
      input md_host,
      input bus_width_config_pin,
      output md_dev,
      output md_dev_oe
   );
   modport host (
      output cs,
      output dc,
      output wr,
      output rd,
      output md_host,
      output bus_width_config_pin,
      input md_dev,
      input md_dev_oe
   );
endinterface : clkcfg_if

//--- hdl/clkcfg_device.sv
// clock block of the lcd controller: registers, pll model, panel divider
`timescale 1ns/1ps
`include "clkcfg_cfg.svh"
module clkcfg_device #(
   parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host bus
   clkcfg_if.device bus,
   // reference clock and clock outputs
   input wire logic ref_clock_input,
   output logic system_clock,
   output logic panel_clock,
   output logic pll_input_clock,
   // clock availability for memory, gamma and panel users
   output logic mem_access_ok,
   output logic panel_out_ok,
   // memory and gamma data ports
   output logic [15:0] mem_wdata,
   output logic mem_wstrobe,
   output logic [17:0] mem_addr,
   output logic gamma_wstrobe,
   output logic [7:0] gamma_wdata
);
   logic [6:0] addr_r;
   logic wr_d_r;
   logic rd_d_r;
   logic [5:0] div_r;
   logic [7:0] set_r [0:3];
   logic [6:0] mult_r;
   logic [7:0] spare_r;
   logic [4:0] pdiv_r;
   logic src_r;
   logic sleep_r;
   logic [7:0] hi_byte_r;
   clkcfg_pkg::pll_state_t pll_state_r;
   logic [31:0] settle_r;
   logic [5:0] ref_cnt_r;
   logic pllin_r;
   logic [6:0] mul_cnt_r;
   logic pllout_r;
   logic [4:0] pc_cnt_r;
   logic pc_hi_r;
   logic sys_d_r;
   logic [15:0] rdata_r;
   logic [17:0] mem_addr_r;
   logic [15:0] mem_wdata_r;
   logic mem_wstrobe_r;
   logic gamma_wstrobe_r;
   logic [7:0] gamma_wdata_r;
   logic wr_edge;
   logic rd_edge;
   logic cfg_write;
   logic [7:0] wbyte;

   ////////////////////////////////////////////////////////////////////////////
   // bus cycle decode: registers update on the strobe edge itself
   assign wr_edge = bus.cs && bus.wr && !wr_d_r;
   assign rd_edge = bus.cs && bus.rd && !rd_d_r;
   assign wbyte = bus.md_host[7:0];
   assign cfg_write = wr_edge && bus.dc;

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_d_r <= 1'b0;
         rd_d_r <= 1'b0;
      end else begin
         wr_d_r <= bus.cs && bus.wr;
         rd_d_r <= bus.cs && bus.rd;
      end
   end

   // address pointer: command phase loads it, data writes advance it except at the memory and gamma ports
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_r <= 7'h00;
      end else if (wr_edge && !bus.dc) begin
         addr_r <= bus.md_host[6:0];
      end else if (cfg_write && addr_r != `OFS_MEM_PORT_LO && addr_r != `OFS_GAMMA_DATA) begin
         addr_r <= addr_r + 7'h02;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers, all zero after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         div_r <= 6'h00;
         mult_r <= 7'h00;
         spare_r <= `RESET_BYTE;
         pdiv_r <= 5'h00;
         src_r <= 1'b0;
         sleep_r <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            set_r[i] <= `RESET_BYTE;
         end
      end else if (cfg_write) begin
         unique case (addr_r)
            `OFS_PLL_INPUT_DIVIDER: div_r <= wbyte[5:0];
            `OFS_PLL_SETTING_0: set_r[0] <= wbyte;
            `OFS_PLL_SETTING_1: set_r[1] <= wbyte;
            `OFS_PLL_SETTING_2: set_r[2] <= wbyte;
            `OFS_PLL_SETTING_3: set_r[3] <= wbyte;
            `OFS_PLL_MULTIPLIER: mult_r <= wbyte[6:0];
            `OFS_DUMMY_INCREMENT: spare_r <= wbyte;
            `OFS_CLOCK_SOURCE_SELECT: begin
               pdiv_r <= wbyte[7:3];
               src_r <= wbyte[`BIT_SRC_SEL];
            end
            `OFS_SLEEP: sleep_r <= wbyte[`BIT_SLEEP];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory and gamma ports; refused while the system clock is unusable
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_addr_r <= 18'h00000;
         mem_wdata_r <= 16'h0000;
         mem_wstrobe_r <= 1'b0;
         gamma_wstrobe_r <= 1'b0;
         gamma_wdata_r <= 8'h00;
         hi_byte_r <= 8'h00;
      end else begin
         mem_wstrobe_r <= 1'b0;
         gamma_wstrobe_r <= 1'b0;
         if (cfg_write && addr_r == `OFS_MEM_PORT_LO && mem_access_ok) begin
            if (bus.bus_width_config_pin) begin
               mem_wdata_r <= bus.md_host;
               mem_wstrobe_r <= 1'b1;
               mem_addr_r <= mem_addr_r + 18'h00002;
            end else begin
               hi_byte_r <= wbyte;
               mem_wdata_r <= {wbyte, hi_byte_r};
               mem_wstrobe_r <= mem_addr_r[0];
               mem_addr_r <= mem_addr_r + 18'h00001;
            end
         end
         if (cfg_write && addr_r == `OFS_GAMMA_DATA && mem_access_ok) begin
            gamma_wdata_r <= wbyte;
            gamma_wstrobe_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pll lock: settles only out of sleep, restarts on any input divider or multiplier write
   always_ff @(posedge clk) begin
      if (rst) begin
         pll_state_r <= clkcfg_pkg::PLL_OFF;
         settle_r <= 32'h00000000;
      end else if (sleep_r) begin
         pll_state_r <= clkcfg_pkg::PLL_OFF;
         settle_r <= 32'h00000000;
      end else if (cfg_write && (addr_r == `OFS_PLL_INPUT_DIVIDER ||
                                 addr_r == `OFS_PLL_MULTIPLIER)) begin
         pll_state_r <= clkcfg_pkg::PLL_SETTLING;
         settle_r <= 32'h00000000;
      end else begin
         unique case (pll_state_r)
            clkcfg_pkg::PLL_OFF: pll_state_r <= clkcfg_pkg::PLL_SETTLING;
            clkcfg_pkg::PLL_SETTLING: begin
               settle_r <= settle_r + 32'h00000001;
               if (settle_r >= SETTLE_CYCLES - 1) begin
                  pll_state_r <= clkcfg_pkg::PLL_LOCKED;
               end
            end
            clkcfg_pkg::PLL_LOCKED: ;
            default: pll_state_r <= clkcfg_pkg::PLL_OFF;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pll model: one input edge per div+1 clocks, one output edge per mult+1 clocks, counted independently
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_cnt_r <= 6'h00;
         pllin_r <= 1'b0;
         mul_cnt_r <= 7'h00;
         pllout_r <= 1'b0;
      end else begin
         if (ref_cnt_r >= div_r) begin
            ref_cnt_r <= 6'h00;
            pllin_r <= ~pllin_r;
         end else begin
            ref_cnt_r <= ref_cnt_r + 6'h01;
         end
         if (mul_cnt_r >= mult_r) begin
            mul_cnt_r <= 7'h00;
            pllout_r <= ~pllout_r;
         end else begin
            mul_cnt_r <= mul_cnt_r + 7'h01;
         end
      end
   end

   // source select; pll side stands low until locked
   assign system_clock = src_r ? (pllout_r && pll_state_r == clkcfg_pkg::PLL_LOCKED)
                               : ref_clock_input;
   assign pll_input_clock = pllin_r;
   assign mem_access_ok = !src_r || pll_state_r == clkcfg_pkg::PLL_LOCKED;
   assign panel_out_ok = mem_access_ok && pdiv_r != 5'h00;

   ////////////////////////////////////////////////////////////////////////////
   // panel clock: toggles every pdiv+1 system clock edges, so odd ratios stay 50/50
   always_ff @(posedge clk) begin
      if (rst) begin
         sys_d_r <= 1'b0;
         pc_cnt_r <= 5'h00;
         pc_hi_r <= 1'b0;
      end else begin
         sys_d_r <= system_clock;
         if (pdiv_r == 5'h00) begin
            pc_cnt_r <= 5'h00;
            pc_hi_r <= 1'b0;
         end else if (system_clock != sys_d_r) begin
            if (pc_cnt_r >= pdiv_r) begin
               pc_cnt_r <= 5'h00;
               pc_hi_r <= ~pc_hi_r;
            end else begin
               pc_cnt_r <= pc_cnt_r + 5'h01;
            end
         end
      end
   end

   assign panel_clock = pc_hi_r;

   ////////////////////////////////////////////////////////////////////////////
   // read data: one cycle after the read strobe edge, lock bit live
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= 16'h0000;
      end else if (rd_edge) begin
         unique case (addr_r)
            `OFS_PLL_INPUT_DIVIDER: rdata_r <= {8'h00,
               pll_state_r == clkcfg_pkg::PLL_LOCKED, 1'b0, div_r};
            `OFS_PLL_SETTING_0: rdata_r <= {8'h00, set_r[0]};
            `OFS_PLL_SETTING_1: rdata_r <= {8'h00, set_r[1]};
            `OFS_PLL_SETTING_2: rdata_r <= {8'h00, set_r[2]};
            `OFS_PLL_SETTING_3: rdata_r <= {8'h00, set_r[3]};
            `OFS_PLL_MULTIPLIER: rdata_r <= {9'h000, mult_r};
            `OFS_DUMMY_INCREMENT: rdata_r <= {8'h00, spare_r};
            `OFS_CLOCK_SOURCE_SELECT: rdata_r <= {8'h00, pdiv_r, 2'b00, src_r};
            `OFS_SLEEP: rdata_r <= {14'h0000, sleep_r, 1'b0};
            default: rdata_r <= 16'h0000;
         endcase
      end
   end

   assign bus.md_dev = rdata_r;
   assign bus.md_dev_oe = rd_d_r;
   assign mem_addr = mem_addr_r;
   assign mem_wdata = mem_wdata_r;
   assign mem_wstrobe = mem_wstrobe_r;
   assign gamma_wstrobe = gamma_wstrobe_r;
   assign gamma_wdata = gamma_wdata_r;
endmodule : clkcfg_device

//--- hdl/clkcfg_host.sv
// host controller: register accesses and the pll switch-over sequence
`timescale 1ns/1ps
module clkcfg_host (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // device bus
   clkcfg_if.host bus,
   // strap
   input wire logic wide_bus,
   // software port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   output logic irq
);
   `include "clkcfg_cfg.svh"

   typedef enum logic [3:0] {
      H_IDLE = 4'b0000,
      H_CMD = 4'b0001,
      H_CMD_END = 4'b0010,
      H_DATA = 4'b0011,
      H_DATA_END = 4'b0100,
      H_RD_WAIT = 4'b0101,
      H_NEXT = 4'b0110
   } hstate_t;

   hstate_t st_r;
   logic [7:0] acc_addr_r;
   logic [7:0] acc_wdata_r;
   logic [7:0] acc_rdata_r;
   logic acc_read_r;
   logic [3:0] seq_step_r;
   logic seq_run_r;
   logic [1:0] status_r;
   logic [1:0] mask_r;
   logic [7:0] rdata_r;
   logic done_evt;
   logic lock_evt;
   logic [7:0] seq_a;
   logic [7:0] seq_d;
   logic seq_rd;

   ////////////////////////////////////////////////////////////////////////////
   // pll switch-over sequence: sleep, divider, settings, multiplier, source, wake, poll lock
   always_comb begin
      seq_rd = 1'b0;
      seq_a = 8'h00;
      seq_d = 8'h00;
      unique case (seq_step_r)
         4'h0: begin seq_a = {1'b0, `OFS_SLEEP}; seq_d = 8'h02; end
         4'h1: begin seq_a = {1'b0, `OFS_PLL_INPUT_DIVIDER}; seq_d = acc_wdata_r; end
         4'h2: begin seq_a = {1'b0, `OFS_PLL_SETTING_0}; seq_d = `SETTING_0_VALUE; end
         4'h3: begin seq_a = {1'b0, `OFS_PLL_SETTING_1}; seq_d = `SETTING_1_VALUE; end
         4'h4: begin seq_a = {1'b0, `OFS_PLL_SETTING_2}; seq_d = `SETTING_2_VALUE; end
         4'h5: begin seq_a = {1'b0, `OFS_PLL_SETTING_3}; seq_d = `SETTING_3_VALUE; end
         4'h6: begin seq_a = {1'b0, `OFS_PLL_MULTIPLIER}; seq_d = acc_rdata_r; end
         4'h7: begin seq_a = {1'b0, `OFS_CLOCK_SOURCE_SELECT}; seq_d = 8'h09; end
         4'h8: begin seq_a = {1'b0, `OFS_SLEEP}; seq_d = 8'h00; end
         default: begin seq_a = {1'b0, `OFS_PLL_INPUT_DIVIDER}; seq_rd = 1'b1; end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus engine: command cycle then one data cycle, each strobe one clock
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= H_IDLE;
         acc_addr_r <= 8'h00;
         acc_wdata_r <= 8'h00;
         acc_rdata_r <= 8'h00;
         acc_read_r <= 1'b0;
         seq_step_r <= 4'h0;
         seq_run_r <= 1'b0;
      end else begin
         unique case (st_r)
            H_IDLE: begin
               if (wr_stb && addr == {1'b0, `OFS_CTL_ADDR}) acc_addr_r <= wdata;
               if (wr_stb && addr == {1'b0, `OFS_CTL_WDATA}) acc_wdata_r <= wdata;
               if (wr_stb && addr == {1'b0, `OFS_CTL_RDATA}) acc_rdata_r <= wdata;
               if (wr_stb && addr == {1'b0, `OFS_CTL_CMD}) begin
                  acc_read_r <= wdata[0];
                  seq_run_r <= wdata[1];
                  seq_step_r <= 4'h0;
                  st_r <= H_CMD;
               end
            end
            H_CMD: st_r <= H_CMD_END;
            H_CMD_END: st_r <= H_DATA;
            H_DATA: st_r <= H_DATA_END;
            H_DATA_END: st_r <= H_RD_WAIT;
            H_RD_WAIT: begin
               if (seq_run_r && (seq_rd || acc_read_r)) begin
                  if (bus.md_dev[`BIT_LOCK]) begin
                     seq_run_r <= 1'b0;
                  end
               end else if (!seq_run_r && acc_read_r) begin
                  acc_rdata_r <= bus.md_dev[7:0];
               end
               st_r <= H_NEXT;
            end
            H_NEXT: begin
               if (seq_run_r) begin
                  if (seq_step_r != 4'h9) seq_step_r <= seq_step_r + 4'h1;
                  st_r <= H_CMD;
               end else begin
                  st_r <= H_IDLE;
               end
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end

   // bus pins follow the engine state
   always_comb begin
      bus.cs = st_r != H_IDLE && st_r != H_NEXT;
      bus.dc = st_r == H_DATA || st_r == H_DATA_END || st_r == H_RD_WAIT;
      bus.rd = st_r == H_DATA && (seq_run_r ? seq_rd : acc_read_r);
      bus.wr = st_r == H_CMD || (st_r == H_DATA && !(seq_run_r ? seq_rd : acc_read_r));
      bus.md_host = 16'h0000;
      if (st_r == H_CMD || st_r == H_CMD_END) begin
         bus.md_host = {8'h00, seq_run_r ? seq_a : acc_addr_r};
      end else if (st_r == H_DATA || st_r == H_DATA_END) begin
         bus.md_host = {8'h00, seq_run_r ? seq_d : acc_wdata_r};
      end
      bus.bus_width_config_pin = wide_bus;
   end

   ////////////////////////////////////////////////////////////////////////////
   // events: access done and pll locked; set wins over read clear
   assign done_evt = st_r == H_NEXT && !seq_run_r;
   assign lock_evt = st_r == H_RD_WAIT && seq_run_r && seq_rd && bus.md_dev[`BIT_LOCK];

   always_ff @(posedge clk) begin
      if (rst) begin
         status_r <= 2'b00;
      end else begin
         status_r <= (rd_stb && addr == {1'b0, `OFS_CTL_STATUS} ? 2'b00 : status_r) |
                     {lock_evt, done_evt};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mask_r <= 2'b00;
      end else if (wr_stb && addr == {1'b0, `OFS_CTL_MASK}) begin
         mask_r <= wdata[1:0];
      end
   end

   // software read port, data one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (rd_stb) begin
         unique case (addr)
            {1'b0, `OFS_CTL_CMD}: rdata_r <= {6'h00, seq_run_r, st_r != H_IDLE};
            {1'b0, `OFS_CTL_STATUS}: rdata_r <= {6'h00, status_r};
            {1'b0, `OFS_CTL_MASK}: rdata_r <= {6'h00, mask_r};
            {1'b0, `OFS_CTL_ADDR}: rdata_r <= acc_addr_r;
            {1'b0, `OFS_CTL_WDATA}: rdata_r <= acc_wdata_r;
            {1'b0, `OFS_CTL_RDATA}: rdata_r <= acc_rdata_r;
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   assign rdata = rdata_r;
   assign irq = |(status_r & mask_r);
endmodule : clkcfg_host

//--- testbench/clkcfg_asserts.sv
// concurrent checks on the host bus
`timescale 1ns/1ps
module clkcfg_asserts #(
   parameter int unsigned SETTLE_CYCLES = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host bus
   input wire logic cs,
   input wire logic dc,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] md_host,
   input wire logic [15:0] md_dev,
   input wire logic md_dev_oe,
   input wire logic bus_width_config_pin
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic wr_d_r;
   logic rd_d_r;
   logic sleep_r;
   logic armed_r;
   logic [6:0] addr_r;
   logic [7:0] shadow_r [0:127];
   int unsigned since_r;
   wire wr_go = cs && wr && !wr_d_r;
   wire rd_go = cs && rd && !rd_d_r;
   wire ans04 = md_dev_oe && addr_r == 7'h04;
   wire lock_evt = wr_go && dc && (addr_r == 7'h04 || addr_r == 7'h0E || addr_r == 7'h56);
   ////////////////////////////////////////////////////////////////////////////////
   // address pointer and register shadow
   always_ff @(posedge clk) begin
      wr_d_r <= cs && wr;
      rd_d_r <= cs && rd;
      if (rst) begin
         addr_r <= 7'h00;
         sleep_r <= 1'b0;
         for (int i = 0; i < 128; i++) begin
            shadow_r[i] <= 8'h00;
         end
      end else if (wr_go && !dc) begin
         addr_r <= md_host[6:0];
      end else if (wr_go) begin
         shadow_r[addr_r] <= md_host[7:0];
         if (addr_r == 7'h56) sleep_r <= md_host[1];
         if (addr_r != 7'h48 && addr_r != 7'h54) addr_r <= addr_r + 7'h02;
      end
   end
   // cycles since the pll was last disturbed, saturating so it never wraps
   always_ff @(posedge clk) begin
      if (rst) begin
         since_r <= 0;
         armed_r <= 1'b0;
      end else if (lock_evt) begin
         since_r <= 0;
         armed_r <= 1'b1;
      end else if (since_r < SETTLE_CYCLES + 100) begin
         since_r <= since_r + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_read_answer: assert property (rd_go |-> ##[0:2] md_dev_oe)
      else $error("register read got no answer");
   a_oe_not_write: assert property (md_dev_oe |-> cs && !wr)
      else $error("device drives data during a write");
   a_one_strobe: assert property (!(wr && rd))
      else $error("write and read strobes together");
   a_write_held: assert property (wr_go |=> cs)
      else $error("select dropped right after write");
   a_lock_in_sleep: assert property (ans04 && sleep_r |-> !md_dev[7])
      else $error("lock flag high in sleep");
   a_lock_settling: assert property (ans04 && armed_r && since_r + 2 < SETTLE_CYCLES |-> !md_dev[7])
      else $error("lock flag high before settling");
   a_lock_settled: assert property (ans04 && armed_r && !sleep_r && since_r > SETTLE_CYCLES + 8
      |-> md_dev[7])
      else $error("lock flag low after settling");
   a_div_readback: assert property (ans04 |-> md_dev[5:0] == shadow_r[4][5:0])
      else $error("reference divider readback wrong");
   a_fixed_readback: assert property (md_dev_oe && addr_r inside {7'h06, 7'h08, 7'h0A, 7'h0C}
      |-> md_dev[7:0] == shadow_r[addr_r])
      else $error("pll setting readback wrong");
   a_mult_readback: assert property (md_dev_oe && addr_r == 7'h0E
      |-> md_dev[6:0] == shadow_r[14][6:0])
      else $error("multiplier readback wrong");
   a_src_readback: assert property (md_dev_oe && addr_r == 7'h12
      |-> md_dev[7:3] == shadow_r[18][7:3] && md_dev[0] == shadow_r[18][0])
      else $error("source select readback wrong");
   c_lock_read: cover property (ans04 && md_dev[7]);
   c_mem_write: cover property (wr_go && dc && addr_r == 7'h48);
   c_sleep_exit: cover property (wr_go && dc && addr_r == 7'h56 && !md_host[1]);
endmodule : clkcfg_asserts

//--- testbench/lcd_controller_clock_config_tb_top.sv
// self-checking bench for the host controller and clock block
`timescale 1ns/1ps
module lcd_controller_clock_config_tb_top;
   localparam int unsigned SETTLE = 60;
   typedef struct packed {logic [7:0] val; logic [7:0] msk;} note_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wide_bus = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic rd_d = 1'b0;
   logic ref_clock_input = 1'b0;
   logic [7:0] rdata, mdiv, mult, v;
   logic irq, system_clock, panel_clock, pll_input_clock, mem_access_ok, panel_out_ok;
   logic mem_wstrobe, gamma_wstrobe;
   logic [15:0] mem_wdata;
   logic [17:0] mem_addr;
   logic [7:0] gamma_wdata;
   logic [7:0] ofs [6] = '{8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E};
   logic [7:0] fixed [4] = '{8'hF8, 8'h80, 8'h28, 8'h00};
   int divs [3] = '{1, 2, 31};
   note_t rq[$];
   note_t nt;
   logic [15:0] mq[$];
   int fails = 0;
   int cmp_count = 0;
   realtime t0, t1, t2;
   clkcfg_if bus_if ();
   clkcfg_device #(.SETTLE_CYCLES(SETTLE)) u_clkcfg_device (.clk(clk), .rst(rst),
      .bus(bus_if.device), .ref_clock_input(ref_clock_input), .system_clock(system_clock),
      .panel_clock(panel_clock), .pll_input_clock(pll_input_clock),
      .mem_access_ok(mem_access_ok), .panel_out_ok(panel_out_ok), .mem_wdata(mem_wdata),
      .mem_wstrobe(mem_wstrobe), .mem_addr(mem_addr), .gamma_wstrobe(gamma_wstrobe),
      .gamma_wdata(gamma_wdata));
   clkcfg_host u_clkcfg_host (.clk(clk), .rst(rst), .bus(bus_if.host), .wide_bus(wide_bus),
      .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq));
   clkcfg_asserts #(.SETTLE_CYCLES(SETTLE)) u_clkcfg_asserts (.clk(clk), .rst(rst),
      .cs(bus_if.cs), .dc(bus_if.dc), .wr(bus_if.wr), .rd(bus_if.rd), .md_host(bus_if.md_host),
      .md_dev(bus_if.md_dev), .md_dev_oe(bus_if.md_dev_oe),
      .bus_width_config_pin(bus_if.bus_width_config_pin));
   ////////////////////////////////////////////////////////////////////////////////
   // reference at half the bench clock, its edges on clock edges
   always #4 clk = ~clk;
   always @(posedge clk) ref_clock_input <= ~ref_clock_input;
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up
   // monitor: read data and port strobes against the oldest note
   always @(posedge clk) begin
      if (rd_d && rq.size() > 0) begin
         nt = rq.pop_front();
         if (nt.msk != 8'h00) check({8'h00, rdata & nt.msk}, {8'h00, nt.val & nt.msk});
      end
      if (mem_wstrobe === 1'b1 || gamma_wstrobe === 1'b1) begin
         if (mq.size() == 0) check(16'(mem_wstrobe) + 16'(gamma_wstrobe), 16'h0000);
         else check(mem_wstrobe ? mem_wdata : {8'h00, gamma_wdata}, mq.pop_front());
      end
      rd_d <= rd_stb;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // software port tasks; a zero mask marks an uncompared poll
   task automatic sw_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : sw_wr
   task automatic sw_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      rq.push_back('{val: e, msk: m});
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
   endtask : sw_rd
   task automatic wait_idle(input int limit);
      int i;
      for (i = 0; i < limit; i++) begin
         sw_rd(8'h00, 8'h00, 8'h00);
         if (rdata[1:0] === 2'b00) break;
      end
      if (i == limit) begin
         check(16'(rdata), 16'h0000);
         wrap_up();
      end
   endtask : wait_idle
   task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
      sw_wr(8'h03, a);
      sw_wr(8'h04, d);
      sw_wr(8'h00, 8'h00);
      wait_idle(50);
   endtask : dev_wr
   task automatic dev_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      sw_wr(8'h03, a);
      sw_wr(8'h00, 8'h01);
      wait_idle(50);
      sw_rd(8'h05, e, m);
   endtask : dev_rd
   // waits for the panel clock to next change to a level, sampling between edges
   task automatic find(input logic lvl, output realtime t);
      int k;
      for (k = 0; k < 2000 && panel_clock === lvl; k++) #1;
      for (k = 0; k < 2000 && panel_clock !== lvl; k++) #1;
      if (k == 2000) begin
         check(16'(panel_clock), 16'(lvl));
         wrap_up();
      end
      t = $realtime;
   endtask : find
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(46589));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      foreach (ofs[i]) dev_rd(ofs[i], 8'h00, 8'h3F);
      check(16'(irq), 16'h0000);
      $display("test reset_values done");
      foreach (ofs[i]) begin
         v = (i == 0) ? 8'($urandom_range(32, 0)) : 8'($urandom);
         dev_wr(ofs[i], v);
         dev_rd(ofs[i], v, (i == 0) ? 8'hBF : ((i == 5) ? 8'h7F : 8'hFF));
      end
      $display("test readback done");
      foreach (divs[i]) begin
         dev_wr(8'h12, {divs[i][4:0], 3'b000});
         #0.5;
         check(16'(system_clock), 16'(ref_clock_input));
         find(1'b1, t0);
         find(1'b1, t0);
         find(1'b0, t1);
         find(1'b1, t2);
         check(16'(int'(t2 - t0)), 16'((divs[i] + 1) * 16));
         check(16'(int'(t1 - t0) * 2), 16'((divs[i] + 1) * 16));
      end
      dev_wr(8'h10, 8'($urandom));
      dev_rd(8'h12, 8'hF8, 8'hF9);
      $display("test panel_divider done");
      mdiv = 8'($urandom_range(32, 0));
      mult = 8'($urandom_range(127, 0));
      sw_wr(8'h02, 8'h02);
      sw_wr(8'h04, mdiv);
      sw_wr(8'h05, mult);
      sw_wr(8'h00, 8'h02);
      wait_idle(400);
      check(16'(irq), 16'h0001);
      sw_rd(8'h01, 8'h02, 8'h02);
      check(16'(irq), 16'h0000);
      foreach (fixed[i]) dev_rd(8'h06 + 8'(2 * i), fixed[i], 8'hFF);
      dev_rd(8'h04, 8'h80 | mdiv, 8'hBF);
      dev_rd(8'h0E, mult, 8'h7F);
      dev_rd(8'h12, 8'h09, 8'hF9);
      check(16'(mem_access_ok), 16'h0001);
      $display("test pll_switch done");
      v = 8'($urandom);
      mq.push_back({~v, v});
      dev_wr(8'h48, v);
      dev_wr(8'h48, ~v);
      wide_bus <= 1'b1;
      mq.push_back({8'h00, v});
      dev_wr(8'h48, v);
      mq.push_back({8'h00, v});
      dev_wr(8'h54, v);
      mq.push_back({8'h00, ~v});
      dev_wr(8'h54, ~v);
      $display("test data_ports done");
      dev_wr(8'h56, 8'h02);
      check(16'(mem_access_ok), 16'h0000);
      dev_wr(8'h54, v);
      dev_rd(8'h04, 8'h00, 8'h80);
      dev_wr(8'h56, 8'h00);
      dev_wr(8'h0E, mult);
      dev_rd(8'h04, 8'h00, 8'h80);
      repeat (SETTLE + 20) @(posedge clk);
      dev_rd(8'h04, 8'h80, 8'h80);
      check(16'(mem_access_ok), 16'h0001);
      repeat (4) @(posedge clk);
      $display("test relock done");
      wrap_up();
   end
endmodule : lcd_controller_clock_config_tb_top
